// File: hdl/ecp_pkg.sv
/*
  Shared constants and types for the extended-capabilities parallel port
  control block: register offsets, field positions, modes, engine states
  and timing counts. Assumes a 20 MHz system clock.
*/
package ecp_pkg;
  localparam logic [10:0] ADR_DATA = 11'h000;
  localparam logic [10:0] ADR_FIFO = 11'h400;
  localparam logic [10:0] ADR_CFGB = 11'h401;
  localparam logic [10:0] ADR_ECR = 11'h402;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int CNT_W = 5;
  localparam int TAG_BIT = 8;
  localparam int RLE_BIT = 7;

  localparam logic [7:0] CFGA_VAL = 8'h10;
  localparam int CFGB_COMP = 7;
  localparam int CFGB_IRQ = 6;

  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_FAULT = 4;
  localparam int ECR_DMA = 3;
  localparam int ECR_SVC = 2;
  localparam int ECR_FULL = 1;
  localparam int ECR_EMPTY = 0;

  localparam logic ECR_FAULT_RST = 1'b1;
  localparam logic ECR_DMA_RST = 1'b0;
  localparam logic ECR_SVC_RST = 1'b1;

  typedef enum logic [2:0] {
    MODE_SPP = 3'b000,
    MODE_PS2 = 3'b001,
    MODE_CFIFO = 3'b010,
    MODE_ECP = 3'b011,
    MODE_EPP = 3'b100,
    MODE_RSVD = 3'b101,
    MODE_TEST = 3'b110,
    MODE_CFG = 3'b111
  } ecp_mode_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_FSETUP = 3'b001,
    ENG_FSTB = 3'b010,
    ENG_FREL = 3'b011,
    ENG_RWAIT = 3'b100,
    ENG_RACK = 3'b101,
    ENG_RPUSH = 3'b110
  } ecp_eng_t;

  localparam int CLK_PERIOD_NS = 50;
  localparam int IRQ_PULSE_NS = 100;
  localparam int DATA_SETUP_NS = 500;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
    IRQ_PULSE_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYC =
    (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] IRQ_PULSE_CNT = 4'(IRQ_PULSE_CYC);
  localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
endpackage : ecp_pkg

// File: hdl/ecp_port_ctrl.sv
/*
  Extended control logic of an ECP-capable parallel port: mode register,
  service and fault interrupts, DMA request, configuration registers,
  a 16-word FIFO and the forward/reverse link handshake engine.
  Assumes host strobes and all pins are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ecp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [AW:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire do_wr = wr_valid & wr_ready;
  wire do_rd = rd_valid & rd_ready;

  assign wr_ready = cnt_r != (AW+1)'(DEPTH);
  assign rd_valid = cnt_r != '0;
  assign rd_data = mem[rp_r];
  assign count = cnt_r;

  always_ff @(posedge sys_clk)
    if (do_wr)
      mem[wp_r] <= wr_data;

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else if (clear)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_r + AW'(do_wr);
      rp_r <= rp_r + AW'(do_rd);
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
endmodule : ecp_fifo

// Functional notes
// - Config B bit 7 reads zero, writes ignored; no hardware compression.
// - Config B bit 6 returns the live interrupt request line level.
// - Mode field, top three bits of extended control, readable in all modes.
// - ECP mode fault falling edge or enable-while-faulted raises an interrupt.
// - DMA enable allows requests once service bit is clear; zero blocks DMA.
// - Service bit blocks DMA and service interrupts; hardware sets it.
// - With DMA enabled, terminal count sets the service bit.
// - Without DMA, free space or fill threshold sets the service bit.
// - Full bit shows FIFO cannot accept; empty bit shows no data.
// - Mode 000 clears FIFO, control lines open-collector, data always driven.
// - Mode 001 direction tri-states data; data reads return pin levels.
// - Mode 010 sends FIFO bytes with compatibility handshake, forward only.
// - Mode 011 sends data and commands by ECP handshake, reverse fills FIFO.
// - Mode 100 is EPP only when the option is configured; 101 reserved.
// - Mode 110 host reads and writes FIFO, nothing sent on lines.
// - Mode 111 maps config A and B at 0x400 and 0x401.
// - Leave 000/001 to anything; other modes only return to 000/001.
// - Transfer direction changes only while in mode 001.
// - Leaving ECP reverse releases auto feed at once and drops extra data.
// - Forward data sent with HostAck high, commands with HostAck low.
// - Received run-length count N repeats the next data byte N+1 times.
// - Interrupt is a brief low pulse on the request line, then released.
module ecp_port_ctrl
  import ecp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [10:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic dma_ack_n,
  input wire logic dma_tc,
  output logic dma_req,
  input wire logic direction,
  input wire logic [7:0] pc_data,
  input wire logic [3:0] pc_ctl_n,
  input wire logic [3:0] tx_free_level,
  input wire logic [3:0] rx_fill_level,
  input wire logic epp_option_config,
  output logic epp_mode_active,
  input wire logic irq_line_level,
  output logic irq_out,
  output logic irq_oe,
  input wire logic peripheral_fault_n,
  input wire logic ack_in_n,
  input wire logic busy_in,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe,
  output logic strobe_out_n,
  output logic auto_feed_n,
  output logic init_out_n,
  output logic select_in_n,
  output logic [3:0] ctl_oe,
  output logic fifo_wr_ready
);
  ecp_mode_t mode_r;
  ecp_eng_t eng_r;
  ecp_eng_t eng_nxt;
  logic fdis_r, dma_en_r, svc_r, dir_r, fault_prev_r;
  logic [8:0] tx_r;
  logic [7:0] rx_r, last_r;
  logic rx_cmd_r;
  logic [6:0] rep_r;
  logic [3:0] tmr_r, irq_cnt_r;
  logic fifo_rd_valid;
  logic [8:0] fifo_rd_data;
  logic [CNT_W-1:0] fifo_count;

  wire fifo_mode = mode_r == MODE_CFIFO || mode_r == MODE_ECP ||
    mode_r == MODE_TEST;
  wire fifo_clear = mode_r == MODE_SPP || mode_r == MODE_PS2;
  wire dir_eff = (mode_r == MODE_CFIFO) ? 1'b0 : dir_r;
  wire hw_fwd = mode_r == MODE_CFIFO ||
    (mode_r == MODE_ECP && !dir_r);
  wire ecp_rev = mode_r == MODE_ECP && dir_r;
  wire dma_cyc = !dma_ack_n;

  // Register decode
  wire hit_ecr = io_addr == ADR_ECR && !dma_cyc;
  wire hit_cfgb = io_addr == ADR_CFGB && !dma_cyc && mode_r == MODE_CFG;
  wire hit_cfga = io_addr == ADR_FIFO && !dma_cyc && mode_r == MODE_CFG;
  wire hit_cmd = io_addr == ADR_DATA && !dma_cyc && mode_r == MODE_ECP;
  wire hit_fifo = fifo_mode && (dma_cyc || io_addr == ADR_FIFO);
  wire ecr_wr = io_wr && hit_ecr;
  wire host_push = io_wr && (hit_fifo || hit_cmd) &&
    (mode_r == MODE_TEST || !dir_eff);
  wire host_pop = io_rd && hit_fifo &&
    (mode_r == MODE_TEST || ecp_rev);
  wire [8:0] host_word = {hit_cmd, io_wdata};

  // Mode changes are refused unless one end is 000 or 001
  wire [2:0] new_mode = io_wdata[ECR_MODE_LSB +: 3];
  wire mode_ok = fifo_clear || new_mode == MODE_SPP ||
    new_mode == MODE_PS2;

  // Engine FIFO access
  wire eng_pop = eng_r == ENG_IDLE && hw_fwd && fifo_rd_valid;
  wire eng_push = eng_r == ENG_RPUSH && !rx_cmd_r;
  wire fifo_wr_valid = ecp_rev ? eng_push : host_push;
  wire [8:0] fifo_wr_data = ecp_rev ? {1'b0, rx_r} : host_word;
  wire fifo_rd_ready = hw_fwd ? eng_pop : host_pop;

  ecp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(fifo_clear),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(fifo_wr_data),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data),
    .count(fifo_count)
  );

  // Service condition and interrupt sources
  wire [CNT_W-1:0] free_cnt = CNT_W'(FIFO_DEPTH) - fifo_count;
  wire [CNT_W-1:0] tx_thr = CNT_W'(tx_free_level) + CNT_W'(1);
  wire [CNT_W-1:0] rx_thr = CNT_W'(rx_fill_level) + CNT_W'(1);
  wire tc_evt = dma_tc && dma_cyc && dma_en_r;
  wire pio_cond = !dma_en_r && fifo_mode &&
    (dir_eff ? fifo_count >= rx_thr : free_cnt >= tx_thr);
  wire svc_set = !svc_r && (dma_en_r ? tc_evt : pio_cond);
  wire fault_fall = fault_prev_r && !peripheral_fault_n;
  wire fault_irq = mode_r == MODE_ECP && ((!fdis_r && fault_fall) ||
    (ecr_wr && fdis_r && !io_wdata[ECR_FAULT] &&
    !peripheral_fault_n));
  wire irq_start = svc_set || fault_irq;

  // The set wins over a simultaneous write of zero
  wire svc_nxt = svc_set || (ecr_wr ? io_wdata[ECR_SVC] : svc_r);

  assign dma_req = dma_en_r && !svc_r && fifo_mode &&
    (dir_eff ? fifo_rd_valid : fifo_wr_ready);

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      mode_r <= MODE_SPP;
      fdis_r <= ECR_FAULT_RST;
      dma_en_r <= ECR_DMA_RST;
      svc_r <= ECR_SVC_RST;
      dir_r <= 1'b0;
      fault_prev_r <= 1'b1;
    end
    else
    begin
      if (ecr_wr && mode_ok)
        mode_r <= ecp_mode_t'(new_mode);
      if (ecr_wr)
      begin
        fdis_r <= io_wdata[ECR_FAULT];
        dma_en_r <= io_wdata[ECR_DMA];
      end
      svc_r <= svc_nxt;
      if (mode_r == MODE_PS2)
        dir_r <= direction;
      fault_prev_r <= peripheral_fault_n;
    end

  // Shared request line: pulse low, then release
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      irq_cnt_r <= '0;
    else if (irq_start)
      irq_cnt_r <= IRQ_PULSE_CNT;
    else if (irq_cnt_r != '0)
      irq_cnt_r <= irq_cnt_r - 4'h1;
  assign irq_out = 1'b0;
  assign irq_oe = irq_cnt_r != '0;

  // Link engine
  always_comb
  begin
    eng_nxt = eng_r;
    case (eng_r)
      ENG_IDLE:
        if (eng_pop)
          eng_nxt = ENG_FSETUP;
        else if (ecp_rev)
          eng_nxt = ENG_RWAIT;
      ENG_FSETUP:
        if (tmr_r == '0 && !busy_in)
          eng_nxt = ENG_FSTB;
      ENG_FSTB:
        if (busy_in)
          eng_nxt = ENG_FREL;
      ENG_FREL:
        if (!busy_in)
          eng_nxt = ENG_IDLE;
      ENG_RWAIT:
        if (!ack_in_n)
          eng_nxt = ENG_RACK;
      ENG_RACK:
        if (ack_in_n)
          eng_nxt = ENG_RPUSH;
      ENG_RPUSH:
        if (rx_cmd_r || (fifo_wr_ready && rep_r == '0))
          eng_nxt = ENG_IDLE;
      default:
        eng_nxt = ENG_IDLE;
    endcase
    // Mode exit aborts mid-byte; the FIFO clear drops the excess
    if (!hw_fwd && !ecp_rev)
      eng_nxt = ENG_IDLE;
  end

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      eng_r <= ENG_IDLE;
      tx_r <= '0;
      rx_r <= '0;
      rx_cmd_r <= 1'b0;
      rep_r <= '0;
      tmr_r <= '0;
    end
    else
    begin
      eng_r <= eng_nxt;
      if (eng_pop)
      begin
        tx_r <= fifo_rd_data;
        tmr_r <= SETUP_CNT;
      end
      else if (tmr_r != '0)
        tmr_r <= tmr_r - 4'h1;
      if (eng_r == ENG_RWAIT && !ack_in_n)
      begin
        rx_r <= pd_in;
        rx_cmd_r <= !busy_in;
      end
      if (eng_r == ENG_RPUSH && rx_cmd_r && !rx_r[RLE_BIT])
        rep_r <= rx_r[6:0];
      else if (eng_push && fifo_wr_ready && rep_r != '0)
        rep_r <= rep_r - 7'h01;
      if (!ecp_rev)
        rep_r <= '0;
    end

  // Pins
  wire eng_fwd_busy = hw_fwd && eng_r != ENG_IDLE;
  wire ecp_fwd = mode_r == MODE_ECP && !dir_r;
  assign pd_out = eng_fwd_busy ? tx_r[7:0] : pc_data;
  assign pd_oe = mode_r == MODE_SPP || mode_r == MODE_CFIFO ||
    !dir_r;
  assign strobe_out_n = hw_fwd ? eng_r != ENG_FSTB : pc_ctl_n[0];
  assign auto_feed_n = ecp_fwd ? !(eng_fwd_busy && tx_r[TAG_BIT]) :
    ecp_rev ? eng_r != ENG_RWAIT : pc_ctl_n[1];
  assign init_out_n = pc_ctl_n[2];
  assign select_in_n = pc_ctl_n[3];
  wire [3:0] ctl_lvl = {select_in_n, init_out_n, auto_feed_n, strobe_out_n};
  assign ctl_oe = mode_r == MODE_SPP ? ~ctl_lvl : 4'hf;
  assign epp_mode_active = mode_r == MODE_EPP && epp_option_config;

  // Read path
  wire [7:0] ecr_val = {mode_r, fdis_r, dma_en_r, svc_r,
    !fifo_wr_ready, !fifo_rd_valid};
  wire [7:0] cfgb_val = {1'b0, irq_line_level, 6'h00};
  // An empty test FIFO rereads the last byte instead of stalling
  wire [7:0] fifo_val = fifo_rd_valid ? fifo_rd_data[7:0] : last_r;
  wire [7:0] rd_nxt = hit_ecr ? ecr_val :
    hit_cfgb ? cfgb_val :
    hit_cfga ? CFGA_VAL :
    host_pop ? fifo_val :
    (io_addr == ADR_DATA && !dma_cyc) ?
    (mode_r == MODE_PS2 ? pd_in : pc_data) : 8'h00;

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      io_rdata <= '0;
      last_r <= '0;
    end
    else
    begin
      if (io_rd)
        io_rdata <= rd_nxt;
      if (host_pop && fifo_rd_valid)
        last_r <= fifo_rd_data[7:0];
    end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_cfgb_comp_zero: assert property (
    io_rd && hit_cfgb |=> !io_rdata[CFGB_COMP])
    else $error("config B bit 7 not zero");
  a_cfgb_irq_level: assert property (
    io_rd && hit_cfgb |=> io_rdata[CFGB_IRQ] == $past(irq_line_level))
    else $error("config B bit 6 not irq level");
  a_mode_bad_switch: assert property (
    ecr_wr && !mode_ok |=> mode_r == $past(mode_r))
    else $error("illegal mode switch taken");
  a_dma_off_block: assert property (
    !dma_en_r || svc_r |-> !dma_req)
    else $error("dma request while disabled");
  a_tc_sets_svc: assert property (
    tc_evt && !svc_r |=> svc_r ##0 irq_oe)
    else $error("terminal count did not set service bit");
  a_flags_read: assert property (
    io_rd && hit_ecr |=> io_rdata[ECR_FULL] == !$past(fifo_wr_ready) &&
    io_rdata[ECR_EMPTY] == !$past(fifo_rd_valid))
    else $error("full or empty flag wrong");
  a_spp_fifo_clear: assert property (
    mode_r == MODE_SPP ##1 mode_r == MODE_SPP |-> fifo_count == '0)
    else $error("fifo not held empty in mode 000");
  a_irq_pulse_len: assert property (
    $rose(irq_oe) |-> irq_oe ##1 irq_oe)
    else $error("interrupt pulse too short");
  a_fault_irq_edge: assert property (
    mode_r == MODE_ECP && !fdis_r && fault_fall |=> irq_oe)
    else $error("fault edge gave no interrupt");
  a_hostack_cmd: assert property (
    ecp_fwd && eng_r == ENG_FSTB |-> auto_feed_n == !tx_r[TAG_BIT])
    else $error("HostAck does not mark command");
  a_rev_abort_idle: assert property (
    $past(ecp_rev) && !ecp_rev && mode_r != MODE_ECP |=> eng_r == ENG_IDLE)
    else $error("engine not idle after leaving reverse");

  c_svc_irq: cover property (svc_set);
  c_fwd_byte: cover property (eng_r == ENG_FSTB ##[1:20] eng_r == ENG_FREL);
  c_rle_expand: cover property (eng_push && rep_r != '0);
  c_fault_irq: cover property (fault_irq);
endmodule : ecp_port_ctrl

`default_nettype wire

// File: verification/ecp_periph_model.sv
/*
  Behavioural ECP peripheral: answers forward strobes with busy, logs each
  byte with its command tag, and sends queued reverse bytes.
  Assumes all link pins are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ecp_periph_model (
  input wire logic sys_clk,
  input wire logic strobe_out_n,
  input wire logic auto_feed_n,
  input wire logic [7:0] pd_out,
  output logic ack_in_n,
  output logic busy_in,
  output logic [7:0] pd_in
);
  // Set by the bench; zero answers promptly, larger values stall
  int dly = 0;
  logic [8:0] fwd_q[$];
  logic [8:0] rev_q[$];
  logic [8:0] w;
  initial
  begin
    ack_in_n = 1'h1;
    busy_in = 1'h0;
    pd_in = 8'h5a;
    forever
    begin
      @(posedge sys_clk);
      if (!strobe_out_n)
      begin
        fwd_q.push_back({~auto_feed_n, pd_out});
        repeat (dly) @(posedge sys_clk);
        busy_in <= 1'h1;
        while (!strobe_out_n) @(posedge sys_clk);
        repeat (dly) @(posedge sys_clk);
        busy_in <= 1'h0;
      end
      else if (!auto_feed_n && rev_q.size() > 0)
      begin
        w = rev_q.pop_front();
        pd_in <= w[7:0];
        busy_in <= ~w[8];
        repeat (dly + 1) @(posedge sys_clk);
        ack_in_n <= 1'h0;
        while (!auto_feed_n) @(posedge sys_clk);
        ack_in_n <= 1'h1;
        @(posedge sys_clk);
        // Released bus must not look like the last byte
        pd_in <= ~w[7:0];
        busy_in <= 1'h0;
      end
    end
  end
endmodule : ecp_periph_model
`default_nettype wire

// File: verification/tb.sv
/*
  Self-checking bench for the ECP port control block: registers, modes,
  FIFO, service and fault interrupts, DMA and link traffic.
  Assumes ecp_periph_model stands on the link pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ecp_pkg::*;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic [10:0] io_addr = 11'h000;
  logic io_wr = 1'h0;
  logic io_rd = 1'h0;
  logic [7:0] io_wdata = 8'h00;
  logic dma_ack_n = 1'h1;
  logic dma_tc = 1'h0;
  logic direction = 1'h0;
  logic [7:0] pc_data = 8'h00;
  logic [3:0] pc_ctl_n = 4'hf;
  logic [3:0] tx_free_level = 4'h3;
  logic [3:0] rx_fill_level = 4'h7;
  logic epp_option_config = 1'h0;
  logic irq_line_level = 1'h0;
  logic peripheral_fault_n = 1'h1;
  logic [7:0] io_rdata, pd_out, pd_in;
  logic dma_req, epp_mode_active, irq_out, irq_oe, pd_oe, fifo_wr_ready;
  logic strobe_out_n, auto_feed_n, init_out_n, select_in_n;
  logic ack_in_n, busy_in;
  logic [3:0] ctl_oe;
  logic [31:0] seed = 32'h67b3;
  logic [8:0] q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  ecp_port_ctrl ecp_port_ctrl_inst (.sys_clk, .resetn, .io_addr, .io_wr,
    .io_rd, .io_wdata, .io_rdata, .dma_ack_n, .dma_tc, .dma_req, .direction,
    .pc_data, .pc_ctl_n, .tx_free_level, .rx_fill_level, .epp_option_config,
    .epp_mode_active, .irq_line_level, .irq_out, .irq_oe,
    .peripheral_fault_n, .ack_in_n, .busy_in, .pd_in, .pd_out, .pd_oe,
    .strobe_out_n, .auto_feed_n, .init_out_n, .select_in_n, .ctl_oe,
    .fifo_wr_ready);
  ecp_periph_model ecp_periph_model_inst (.sys_clk, .strobe_out_n,
    .auto_feed_n, .pd_out, .ack_in_n, .busy_in, .pd_in);

  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] rnd();
    seed = lfsr(seed);
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] cfgb_exp(input logic irq);
    return {1'h0, irq, 6'h00};
  endfunction : cfgb_exp

  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [8:0] g, input logic [8:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'h1;
    @(posedge sys_clk);
    io_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd <= 1'h1;
    @(posedge sys_clk);
    io_rd <= 1'h0;
    // Sampled one edge later so io_rdata, registered on the previous edge, has settled
    @(posedge sys_clk);
    v = io_rdata;
  endtask : rd
  task automatic ecr(input logic [2:0] m, input logic [2:0] f);
    wr(ADR_ECR, {m, f, 2'h0});
  endtask : ecr
  task automatic dma_wr(input logic [7:0] b);
    @(posedge sys_clk);
    dma_ack_n <= 1'h0;
    dma_tc <= 1'h1;
    io_wr <= 1'h1;
    io_wdata <= b;
    @(posedge sys_clk);
    dma_ack_n <= 1'h1;
    dma_tc <= 1'h0;
    io_wr <= 1'h0;
  endtask : dma_wr
  task automatic irq_chk(input logic e);
    int n;
    int t;
    n = 0;
    t = 0;
    #1;
    while (irq_oe !== 1'h1 && t < 8)
    begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    while (irq_oe === 1'h1 && n < 16)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(9'(n), e ? 9'(IRQ_PULSE_CYC) : 9'h000, "irq pulse");
    @(posedge sys_clk);
  endtask : irq_chk
  task automatic pop_fifo(output logic [7:0] v);
    for (int t = 0; t < 400; t++)
    begin
      rd(ADR_ECR, v);
      if (v[ECR_EMPTY] === 1'h0)
        break;
    end
    rd(ADR_FIFO, v);
  endtask : pop_fifo

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] r;
    logic [8:0] w;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(ADR_ECR, d);
    chk(d, {MODE_SPP, ECR_FAULT_RST, ECR_DMA_RST, ECR_SVC_RST, 2'h1},
      "reset ecr");
    r = rnd();
    pc_data <= rnd();
    pc_ctl_n <= {r[1:0], 2'h3};
    direction <= 1'h1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(pd_oe, 1'h1, "spp drive");
    chk(ctl_oe, 4'(~pc_ctl_n), "open collector");
    chk({select_in_n, init_out_n}, pc_ctl_n[3:2], "ctl pins");
    ecr(MODE_PS2, 3'h5);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(pd_oe, 1'h0, "ps2 float");
    r = pd_in;
    rd(ADR_DATA, d);
    chk(d, r, "ps2 pins");
    direction <= 1'h0;
    irq_line_level <= ~r[0];
    ecr(MODE_CFG, 3'h5);
    rd(ADR_FIFO, d);
    chk(d, CFGA_VAL, "config a");
    wr(ADR_CFGB, 8'hff);
    rd(ADR_CFGB, d);
    chk(d, cfgb_exp(~r[0]), "config b");
    ecr(MODE_ECP, 3'h5);
    rd(ADR_ECR, d);
    chk(d[7:5], MODE_CFG, "mode lock");
    ecr(MODE_SPP, 3'h5);
    for (int o = 0; o < 2; o++)
    begin
      epp_option_config <= o[0];
      ecr(MODE_EPP, 3'h5);
      #1;
      chk(epp_mode_active, o[0], "epp");
      ecr(MODE_SPP, 3'h5);
    end
    ecr(MODE_TEST, 3'h5);
    for (int i = 0; i < 17; i++)
    begin
      r = rnd();
      if (i < 16) q.push_back({1'h0, r});
      wr(ADR_FIFO, r);
    end
    #1;
    chk(fifo_wr_ready, 1'h0, "full ready");
    rd(ADR_ECR, d);
    chk(d[1:0], 2'h2, "full flags");
    chk(9'(ecp_periph_model_inst.fwd_q.size()), 9'h000, "quiet");
    for (int i = 0; i < 17; i++)
    begin
      rd(ADR_FIFO, d);
      chk(d, q[i < 16 ? i : 15], "test fifo");
    end
    rd(ADR_ECR, d);
    chk(d[1:0], 2'h1, "empty flags");
    ecr(MODE_TEST, 3'h4);
    irq_chk(1'h1);
    chk(irq_out, 1'h0, "irq level");
    rd(ADR_ECR, d);
    chk(d[ECR_SVC], 1'h1, "svc set");
    ecr(MODE_TEST, 3'h5);
    irq_chk(1'h0);
    tx_free_level <= 4'hf;
    wr(ADR_FIFO, rnd());
    ecr(MODE_TEST, 3'h4);
    irq_chk(1'h0);
    rd(ADR_FIFO, d);
    irq_chk(1'h1);
    ecr(MODE_SPP, 3'h5);
    ecr(MODE_CFIFO, 3'h7);
    #1;
    chk(dma_req, 1'h0, "dma svc");
    ecr(MODE_CFIFO, 3'h6);
    #1;
    chk(dma_req, 1'h1, "dma on");
    r = rnd();
    dma_wr(r);
    irq_chk(1'h1);
    chk(dma_req, 1'h0, "dma tc");
    for (int t = 0; t < 3000 && ecp_periph_model_inst.fwd_q.size() < 1; t++)
      @(posedge sys_clk);
    w = ecp_periph_model_inst.fwd_q.pop_front();
    chk(w[7:0], r, "compat byte");
    ecr(MODE_CFIFO, 3'h4);
    #1;
    chk(dma_req, 1'h0, "dma off");
    ecr(MODE_SPP, 3'h5);
    ecr(MODE_ECP, 3'h5);
    q.delete();
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      if (i < 2) r[7] = ~i[0];
      q.push_back({i < 2, r});
      ecp_periph_model_inst.dly = i;
      wr(i < 2 ? ADR_DATA : ADR_FIFO, r);
    end
    for (int t = 0; t < 3000 && ecp_periph_model_inst.fwd_q.size() < 4; t++)
      @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
      chk(ecp_periph_model_inst.fwd_q[i], q[i], "ecp fwd");
    direction <= 1'h1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(pd_oe, 1'h1, "dir held");
    @(posedge sys_clk);
    peripheral_fault_n <= 1'h0;
    irq_chk(1'h0);
    ecr(MODE_ECP, 3'h1);
    irq_chk(1'h1);
    peripheral_fault_n <= 1'h1;
    @(posedge sys_clk);
    peripheral_fault_n <= 1'h0;
    irq_chk(1'h1);
    peripheral_fault_n <= 1'h1;
    ecr(MODE_PS2, 3'h5);
    ecr(MODE_ECP, 3'h5);
    r = rnd();
    ecp_periph_model_inst.rev_q.push_back({6'h20, r[2:0]});
    d = rnd();
    ecp_periph_model_inst.rev_q.push_back({1'h0, d});
    q.delete();
    for (int i = 0; i <= r[2:0]; i++)
      q.push_back({1'h0, d});
    for (int i = 0; i < q.size(); i++)
    begin
      pop_fifo(d);
      chk(d, q[i], "rle expand");
    end
    ecp_periph_model_inst.dly = 6;
    ecp_periph_model_inst.rev_q.push_back({1'h0, rnd()});
    repeat (4) @(posedge sys_clk);
    ecr(MODE_PS2, 3'h5);
    #1;
    chk(auto_feed_n, pc_ctl_n[1], "abort feed");
    rd(ADR_ECR, d);
    chk(d[ECR_EMPTY], 1'h1, "abort drop");
    summarize();
  end
endmodule : tb
`default_nettype wire
